// file: crl_lock_top.sv
// code memory protection: lock bits, encryption key, verify path
// assumes cpu and image port run on core_clk_i; the access pin is async
// assumes the access pin is steady for a few cycles around reset release
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module crl_lock_top
  import crl_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ext_access_sel_i,
  output logic ext_access_sel_o,
  input wire logic cpu_rd_i,
  input wire logic [crl_pkg::CODE_AW-1:0] cpu_addr_i,
  input wire logic cpu_table_read_i,
  input wire logic cpu_from_ext_i,
  output logic [7:0] cpu_data_o,
  output logic cpu_refused_o,
  input wire logic [crl_pkg::IMG_AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic wr_refused_o,
  output logic rd_refused_o,
  output crl_pkg::crl_level_type lock_level_o
);

  import crl_pkg::*;

  // ***********************************************************
  // declarations
  // ***********************************************************
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;
  logic ea_meta_reg;
  logic ea_sync_reg;
  logic ea_latched_reg;
  logic ea_latched_next;
  logic ea_out_reg;
  logic ea_out_next;
  crl_phase_type phase_reg;
  crl_phase_type phase_next;
  crl_level_type level_reg;
  crl_level_type level_now;
  logic cpu_refused_reg;
  logic wr_refused_reg;
  logic rd_refused_reg;
  logic [1:0] sec_bits;
  logic [7:0] key_byte;
  logic lock_one;
  logic lock_full;
  logic hit_code;
  logic hit_key;
  logic hit_sec;
  logic code_wr_ok;
  logic key_wr_ok;
  logic sec_wr_ok;
  logic sec_two_dropped;
  logic [7:0] sec_wbyte;
  logic kf_wr;
  logic [KEY_SLOT_W-1:0] kf_slot;
  logic [7:0] kf_wdata;
  logic wr_bad;
  logic vfy_force;
  logic [7:0] vfy_force_val;
  logic rd_bad;
  logic rd_code_locked;
  logic rd_unmapped;
  logic cpu_block;

  // ***********************************************************
  // reset and pin synchronisers
  // ***********************************************************
  // release is synchronised so every flop leaves reset on one edge
  // a mid-run reset behaves alike; stored bytes are never cleared
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  // access pin is asynchronous; only the second flop is read below
  // no reset on purpose: the pair keeps tracking the pin while the core
  // is held, so the capture cycle sees the real pin, not a reset value
  always_ff @(posedge core_clk_i)
  begin
    ea_meta_reg <= ext_access_sel_i;
    ea_sync_reg <= ea_meta_reg;
  end

  // ***********************************************************
  // lock level decode
  // ***********************************************************
  // bit 0 is lock one, bit 1 is lock two, stored zero enables
  assign level_now = crl_level_of(sec_bits);
  // lock two alone is undefined and enforced as open
  assign lock_one = (level_now == LVL_ONE) || (level_now == LVL_FULL);
  assign lock_full = (level_now == LVL_FULL);
  // the undefined code still reaches lock_level_o so software sees it

  // ***********************************************************
  // image address decode
  // ***********************************************************
  // addresses above the lock byte decode to nothing and are refused
  assign hit_code = crl_in_range(addr_i, CODE_BASE, CODE_LAST);
  assign hit_key = crl_in_range(addr_i, KEY_BASE, KEY_LAST);
  assign hit_sec = (addr_i == SEC_ADDR);

  // ***********************************************************
  // programming path
  // ***********************************************************
  // once lock one is set, code and key become read-only for good
  // the lock byte stays writable, since its bits can only be cleared
  assign code_wr_ok = wr_i && hit_code && !lock_one;
  assign key_wr_ok = wr_i && hit_key && !lock_one;
  assign sec_wr_ok = wr_i && hit_sec;

  // lock two is kept blank unless lock one ends up enabled
  assign sec_two_dropped = !wdata_i[SEC_TWO_POS] &&
    wdata_i[SEC_ONE_POS] && sec_bits[SEC_ONE_POS];
  assign sec_wbyte = {SEC_PAD, (wdata_i[SEC_TWO_POS] | sec_two_dropped),
    wdata_i[SEC_ONE_POS]};

  // key file shares one write port between key slots and sec slot
  assign kf_wr = key_wr_ok || sec_wr_ok;
  assign kf_slot = hit_sec ? SEC_SLOT : {1'b0, addr_i[KEY_IW-1:0]};
  assign kf_wdata = hit_sec ? sec_wbyte : wdata_i;

  // a refused write leaves every cell exactly as it was
  // writes blocked by lock one, unmapped writes and lock two alone are flagged
  assign wr_bad = wr_i && !(code_wr_ok || key_wr_ok ||
    (sec_wr_ok && !sec_two_dropped));

  // ***********************************************************
  // verify read path
  // ***********************************************************
  // key selected by low address bits, so 64 bytes repeat
  // over the array; an ffh key byte makes the xnor transparent
  // the key region and holes read blank, the key never leaves
  // the forced value bypasses the array, so a key byte cannot leak out
  assign vfy_force = !hit_code || lock_full;
  assign vfy_force_val = hit_sec ? {SEC_PAD, sec_bits} : BLANK_BYTE;
  // only code reads are blanked by the full lock; the lock byte stays
  // readable and is never flagged, as it returns its real value
  assign rd_code_locked = hit_code && lock_full;
  assign rd_unmapped = !(hit_code || hit_sec);
  assign rd_bad = rd_i && (rd_code_locked || hit_key || rd_unmapped);

  // ***********************************************************
  // cpu fetch and table read path
  // ***********************************************************
  // table reads running from external code are the leak path
  // fetches and table reads from internal code are never blocked,
  // since the core must still run its own program
  assign cpu_block = cpu_rd_i && cpu_table_read_i && cpu_from_ext_i &&
    lock_one;

  // ***********************************************************
  // storage instances
  // ***********************************************************
  // key bytes and lock byte share one small flop file
  crl_key_file u_key_file (
    .clk_i(core_clk_i),
    .wr_i(kf_wr),
    .wslot_i(kf_slot),
    .wdata_i(kf_wdata),
    .ridx_i(addr_i[KEY_IW-1:0]),
    .key_o(key_byte),
    .sec_o(sec_bits)
  );

  // port a serves verify, port b the cpu; the cpu path never sees the key
  // so table reads that are allowed come back in plain form
  crl_code_mem #(
    .DW(8),
    .AW(CODE_AW),
    .DEPTH(CODE_DEPTH)
  ) u_code_mem (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .wr_i(code_wr_ok),
    .waddr_i(addr_i[CODE_AW-1:0]),
    .wdata_i(wdata_i),
    .rd_a_i(rd_i),
    .raddr_a_i(addr_i[CODE_AW-1:0]),
    .mask_a_i(key_byte),
    .force_a_i(vfy_force),
    .force_val_a_i(vfy_force_val),
    .q_a_o(rdata_o),
    .rd_b_i(cpu_rd_i),
    .raddr_b_i(cpu_addr_i),
    .mask_b_i(PLAIN_MASK),
    .force_b_i(cpu_block),
    .force_val_b_i(BLANK_BYTE),
    .q_b_o(cpu_data_o)
  );

  // ***********************************************************
  // start-up phase and access select latch
  // ***********************************************************
  // first cycle after release catches the pin; held until next reset
  // a pin that moves right at release may be caught either way; the
  // synchroniser settles it to one clean level before the capture
  always_comb
  begin
    phase_next = phase_reg;
    ea_latched_next = ea_latched_reg;
    unique case (phase_reg)
      PH_CAPTURE:
      begin
        ea_latched_next = ea_sync_reg;
        phase_next = PH_RUN;
      end
      PH_RUN:
      begin
        phase_next = PH_RUN;
      end
    endcase
  end

  // with lock one the latched copy wins over the live pin
  // without lock one the live pin passes three clock edges later
  assign ea_out_next = lock_one ? ea_latched_next : ea_sync_reg;

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_reg <= PH_CAPTURE;
      ea_latched_reg <= EA_RST;
      ea_out_reg <= EA_RST;
    end
    else
    begin
      phase_reg <= phase_next;
      ea_latched_reg <= ea_latched_next;
      ea_out_reg <= ea_out_next;
    end
  end

  // ***********************************************************
  // status flops
  // ***********************************************************
  // refusal flags are one-cycle pulses after the refused strobe
  // lock_level_o trails a lock byte write by one cycle; enforcement
  // above uses the live stored bits and never waits on it
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_reg <= LVL_OPEN;
      cpu_refused_reg <= 1'b0;
      wr_refused_reg <= 1'b0;
      rd_refused_reg <= 1'b0;
    end
    else
    begin
      level_reg <= level_now;
      cpu_refused_reg <= cpu_block;
      wr_refused_reg <= wr_bad;
      rd_refused_reg <= rd_bad;
    end
  end

  // every output comes straight from a flop
  assign ext_access_sel_o = ea_out_reg;
  assign lock_level_o = level_reg;
  assign cpu_refused_o = cpu_refused_reg;
  assign wr_refused_o = wr_refused_reg;
  assign rd_refused_o = rd_refused_reg;

endmodule
`default_nettype wire

// file: crl_pkg.sv
// constants, types and decode helpers for the code rom security lock
// assumes a single 25 MHz core clock and a byte wide image port
package crl_pkg;

  // ***********************************************************
  // image map
  // ***********************************************************
  localparam int CODE_AW = 14;
  localparam int IMG_AW = 15;
  localparam int CODE_DEPTH = 16384;
  localparam logic [IMG_AW-1:0] CODE_BASE = 15'h0000;
  localparam logic [IMG_AW-1:0] CODE_LAST = 15'h3FFF;
  localparam logic [IMG_AW-1:0] KEY_BASE = 15'h4000;
  localparam logic [IMG_AW-1:0] KEY_LAST = 15'h403F;
  localparam logic [IMG_AW-1:0] SEC_ADDR = 15'h4040;

  // ***********************************************************
  // key array and security byte layout
  // ***********************************************************
  localparam int KEY_BYTES = 64;
  localparam int KEY_IW = 6;
  localparam int KEY_SLOT_W = 7;
  localparam logic [KEY_SLOT_W-1:0] SEC_SLOT = 7'h40;
  localparam int SEC_ONE_POS = 0;
  localparam int SEC_TWO_POS = 1;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  localparam logic [7:0] PLAIN_MASK = 8'hFF;
  localparam logic [5:0] SEC_PAD = 6'h3F;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [7:0] RDATA_RST = 8'hFF;
  localparam logic EA_RST = 1'b0;

  // protection level reported to the core
  typedef enum logic [1:0]
  {
    LVL_OPEN = 2'b00,
    LVL_ONE = 2'b01,
    LVL_FULL = 2'b10,
    LVL_UNDEF = 2'b11
  } crl_level_type;

  // start-up phase after reset release
  typedef enum logic
  {
    PH_CAPTURE = 1'b0,
    PH_RUN = 1'b1
  } crl_phase_type;

  // stored zero means enabled
  function automatic crl_level_type crl_level_of(input logic [1:0] sec);
    crl_level_type lvl;
    lvl = LVL_OPEN;
    if (!sec[SEC_ONE_POS])
      lvl = sec[SEC_TWO_POS] ? LVL_ONE : LVL_FULL;
    else if (!sec[SEC_TWO_POS])
      lvl = LVL_UNDEF;
    return lvl;
  endfunction

  function automatic logic crl_in_range(input logic [IMG_AW-1:0] a,
    input logic [IMG_AW-1:0] lo, input logic [IMG_AW-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

endpackage

// file: crl_code_mem.sv
// user code array with one write port and two registered read ports
// assumes writes and reads come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module crl_code_mem #(
  parameter int DW = 8,
  parameter int AW = 14,
  parameter int DEPTH = 16384
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic rd_a_i,
  input wire logic [AW-1:0] raddr_a_i,
  input wire logic [DW-1:0] mask_a_i,
  input wire logic force_a_i,
  input wire logic [DW-1:0] force_val_a_i,
  output logic [DW-1:0] q_a_o,
  input wire logic rd_b_i,
  input wire logic [AW-1:0] raddr_b_i,
  input wire logic [DW-1:0] mask_b_i,
  input wire logic force_b_i,
  input wire logic [DW-1:0] force_val_b_i,
  output logic [DW-1:0] q_b_o
);

  logic [DW-1:0] store [0:DEPTH-1];
  logic [DW-1:0] q_a_reg;
  logic [DW-1:0] q_b_reg;
  logic [DW-1:0] q_a_next;
  logic [DW-1:0] q_b_next;

  // ***********************************************************
  // storage
  // ***********************************************************
  // blank array reads all ones
  initial
  begin
    for (int i = 0; i < DEPTH; i++)
      store[i] = {DW{1'b1}};
  end

  always_ff @(posedge clk_i)
  begin
    if (wr_i)
      store[waddr_i] <= wdata_i;
  end

  // ***********************************************************
  // read ports
  // ***********************************************************
  // mask of all ones passes data unchanged through the xnor
  assign q_a_next = force_a_i ? force_val_a_i :
    ~(store[raddr_a_i] ^ mask_a_i);
  assign q_b_next = force_b_i ? force_val_b_i :
    ~(store[raddr_b_i] ^ mask_b_i);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q_a_reg <= {DW{1'b1}};
      q_b_reg <= {DW{1'b1}};
    end
    else
    begin
      if (rd_a_i)
        q_a_reg <= q_a_next;
      if (rd_b_i)
        q_b_reg <= q_b_next;
    end
  end

  assign q_a_o = q_a_reg;
  assign q_b_o = q_b_reg;

endmodule
`default_nettype wire

// file: crl_key_file.sv
// key bytes plus the security byte, one-time programmable style
// assumes the caller only writes slots 0 to 64
`timescale 1ns/100ps
`default_nettype none
module crl_key_file
  import crl_pkg::*;
(
  input wire logic clk_i,
  input wire logic wr_i,
  input wire logic [crl_pkg::KEY_SLOT_W-1:0] wslot_i,
  input wire logic [7:0] wdata_i,
  input wire logic [crl_pkg::KEY_IW-1:0] ridx_i,
  output logic [7:0] key_o,
  output logic [1:0] sec_o
);

  logic [7:0] store [0:KEY_BYTES];

  // ***********************************************************
  // storage
  // ***********************************************************
  // unprogrammed cells read as ones
  initial
  begin
    for (int i = 0; i <= KEY_BYTES; i++)
      store[i] = 8'hFF;
  end

  // programming can only clear bits, never set them back
  always_ff @(posedge clk_i)
  begin
    if (wr_i)
      store[wslot_i] <= store[wslot_i] & wdata_i;
  end

  // combinational reads, few bits so no read register needed
  assign key_o = store[{1'b0, ridx_i}];
  assign sec_o = store[SEC_SLOT][1:0];

endmodule
`default_nettype wire

// file: crl_lock_top_pad_note_removed.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// file: crl_lock_asserts.sv
// port level assertions for the code rom security lock
// assumes a bind onto crl_lock_top and the single core clock domain
`timescale 1ns/100ps
`default_nettype none
module crl_lock_asserts
  import crl_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ext_access_sel_i,
  input wire logic ext_access_sel_o,
  input wire logic cpu_rd_i,
  input wire logic cpu_table_read_i,
  input wire logic cpu_from_ext_i,
  input wire logic [7:0] cpu_data_o,
  input wire logic cpu_refused_o,
  input wire logic [crl_pkg::IMG_AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic wr_refused_o,
  input wire logic rd_refused_o,
  input wire crl_pkg::crl_level_type lock_level_o
);
  import crl_pkg::*;

  logic [2:0] up_cnt;
  logic locked;

  // lock one in force, alone or with lock two
  assign locked = (lock_level_o == LVL_ONE) || (lock_level_o == LVL_FULL);

  // settle counter: pin checks skip the capture window after reset
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      up_cnt <= 3'h0;
    else if (up_cnt != 3'h7)
      up_cnt <= up_cnt + 3'h1;
  end

  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // ***********************************************************
  // sequences and properties
  // ***********************************************************
  sequence pin_quiet_s;
    (up_cnt == 3'h7 && lock_level_o == LVL_OPEN &&
      $stable(ext_access_sel_i))[*5];
  endsequence

  sequence two_alone_s;
    wr_i && addr_i == SEC_ADDR && wdata_i[1:0] == 2'h1 &&
      lock_level_o == LVL_OPEN;
  endsequence

  key_rd_blank_a: assert property (
    rd_i && addr_i >= KEY_BASE && addr_i <= KEY_LAST
    |=> rdata_o == BLANK_BYTE && rd_refused_o)
    else $error("key read not blanked");
  verify_off_a: assert property (
    rd_i && addr_i <= CODE_LAST && lock_level_o == LVL_FULL
    |=> rdata_o == BLANK_BYTE && rd_refused_o)
    else $error("verify read not blocked");
  prog_locked_a: assert property (
    wr_i && addr_i <= KEY_LAST && locked |=> wr_refused_o)
    else $error("write not refused under lock");
  unmapped_wr_a: assert property (
    wr_i && addr_i > SEC_ADDR |=> wr_refused_o)
    else $error("unmapped write not refused");
  cpu_block_a: assert property (
    cpu_rd_i && cpu_table_read_i && cpu_from_ext_i && locked
    |=> cpu_refused_o && cpu_data_o == BLANK_BYTE)
    else $error("external table read not blocked");
  cpu_open_a: assert property (
    cpu_rd_i && lock_level_o == LVL_OPEN && !$past(wr_i)
    |=> !cpu_refused_o)
    else $error("open cpu read refused");
  pin_held_a: assert property (
    up_cnt == 3'h7 && locked && $past(locked)
    |-> $stable(ext_access_sel_o))
    else $error("latched access select moved");
  pin_follow_a: assert property (
    pin_quiet_s |-> ext_access_sel_o == ext_access_sel_i)
    else $error("open access select not following pin");
  two_alone_a: assert property (
    two_alone_s |=> wr_refused_o ##1 lock_level_o != LVL_UNDEF)
    else $error("lock two accepted without lock one");
  sec_read_a: assert property (
    rd_i && addr_i == SEC_ADDR
    |=> rdata_o[7:2] == SEC_PAD && !rd_refused_o)
    else $error("lock byte read wrong");
endmodule

bind crl_lock_top crl_lock_asserts u_chk (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .ext_access_sel_i(ext_access_sel_i),
  .ext_access_sel_o(ext_access_sel_o), .cpu_rd_i(cpu_rd_i),
  .cpu_table_read_i(cpu_table_read_i), .cpu_from_ext_i(cpu_from_ext_i),
  .cpu_data_o(cpu_data_o), .cpu_refused_o(cpu_refused_o),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .wr_refused_o(wr_refused_o),
  .rd_refused_o(rd_refused_o), .lock_level_o(lock_level_o)
);
`default_nettype wire

// file: crl_prog_model.sv
// external programmer model: writes and verifies through the image port
// assumes answers land one edge after the strobe edge, no wait states
`timescale 1ns/100ps
`default_nettype none
module crl_prog_model
  import crl_pkg::*;
(
  input wire logic clk_i,
  output logic [crl_pkg::IMG_AW-1:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i,
  input wire logic wr_refused_i,
  input wire logic rd_refused_i
);
  import crl_pkg::*;

  // idle bus at time zero
  initial
  begin
    addr_o = 15'h0000;
    wdata_o = 8'h00;
    wr_o = 1'h0;
    rd_o = 1'h0;
  end

  // one strobe cycle; the idle bus is inverted so stale values never help
  task automatic strobe(input logic w, input logic [IMG_AW-1:0] a,
    input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= w;
    rd_o <= !w;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'h0;
    rd_o <= 1'h0;
    addr_o <= ~a;
    wdata_o <= ~d;
    // refusal pulse stands only in the cycle after the strobe; the answer holds until the next read
    #1;
  endtask

  task automatic prog_write(input logic [IMG_AW-1:0] a,
    input logic [7:0] d, output logic refused);
    strobe(1'h1, a, d);
    refused = wr_refused_i;
  endtask

  task automatic prog_read(input logic [IMG_AW-1:0] a,
    output logic [7:0] q, output logic refused);
    strobe(1'h0, a, 8'h00);
    q = rdata_i;
    refused = rd_refused_i;
  endtask
endmodule
`default_nettype wire

// file: code_rom_security_lock_tb_top.sv
// self-checking bench for the code rom security lock
// assumes fresh blank storage at time zero; locks only ever tighten
`timescale 1ns/100ps
`default_nettype none
module code_rom_security_lock_tb_top;
  import crl_pkg::*;

  typedef struct packed {
    logic w;
    logic [14:0] a;
    logic [7:0] d;
    logic [7:0] q;
    logic f;
  } crl_row_type;

  logic clk = 1'h0, rst_n = 1'h0, pin = 1'h0;
  logic c_rd = 1'h0, c_tbl = 1'h0, c_ext = 1'h0;
  logic [13:0] c_addr = 14'h0000;
  logic pin_o, c_ref, wref, rref, wr, rd, f;
  logic [7:0] c_data, q, d, b;
  logic [14:0] a;
  crl_level_type lvl;
  int compares = 0;
  int num_errors = 0;
  int cycles = 0;

  // open mode rows: write flag, address, data, expected byte, refused
  crl_row_type rows [14] = '{
    '{1'h1, 15'h4010, 8'h0F, 8'h00, 1'h0},
    '{1'h1, 15'h0010, 8'h5A, 8'h00, 1'h0},
    '{1'h0, 15'h0010, 8'h00, 8'hAA, 1'h0},
    '{1'h1, 15'h0050, 8'h3C, 8'h00, 1'h0},
    '{1'h0, 15'h0050, 8'h00, 8'hCC, 1'h0},
    '{1'h1, 15'h3FFF, 8'h81, 8'h00, 1'h0},
    '{1'h0, 15'h3FFF, 8'h00, 8'h81, 1'h0},
    '{1'h0, 15'h0001, 8'h00, 8'hFF, 1'h0},
    '{1'h0, 15'h4010, 8'h00, 8'hFF, 1'h1},
    '{1'h0, 15'h4040, 8'h00, 8'hFF, 1'h0},
    '{1'h1, 15'h4041, 8'h00, 8'h00, 1'h1},
    '{1'h0, 15'h4041, 8'h00, 8'hFF, 1'h1},
    '{1'h1, 15'h4010, 8'hF0, 8'h00, 1'h0},
    '{1'h0, 15'h0010, 8'h00, 8'hA5, 1'h0}
  };

  crl_lock_top dut (
    .core_clk_i(clk), .nrst_i(rst_n), .ext_access_sel_i(pin),
    .ext_access_sel_o(pin_o), .cpu_rd_i(c_rd), .cpu_addr_i(c_addr),
    .cpu_table_read_i(c_tbl), .cpu_from_ext_i(c_ext),
    .cpu_data_o(c_data), .cpu_refused_o(c_ref), .addr_i(a),
    .wdata_i(d), .wr_i(wr), .rd_i(rd), .rdata_o(q),
    .wr_refused_o(wref), .rd_refused_o(rref), .lock_level_o(lvl)
  );

  crl_prog_model prog (
    .clk_i(clk), .addr_o(a), .wdata_o(d), .wr_o(wr), .rd_o(rd),
    .rdata_i(q), .wr_refused_i(wref), .rd_refused_i(rref)
  );

  // 25 MHz core clock
  initial
  begin
    forever #20 clk = ~clk;
  end

  task automatic chk_byte(input string n, input logic [7:0] e,
    input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_byte(n, {7'h00, e}, {7'h00, g});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one cpu code read, answer checked on the following edge
  task automatic cpu_read(input logic t, input logic x,
    input logic [7:0] e, input logic r);
    @(posedge clk);
    c_rd <= 1'h1;
    c_addr <= 14'h0010;
    c_tbl <= t;
    c_ext <= x;
    @(posedge clk);
    c_rd <= 1'h0;
    c_addr <= 14'h3FEF;
    #1;
    chk_byte("cpu_data", e, c_data);
    chk_bit("cpu_refused", r, c_ref);
  endtask

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, far above the hundred or so cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      wrap_up;
    end
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    idle(3);
    chk_byte("level", 8'h00, {6'h00, lvl});
    foreach (rows[i])
    begin
      if (rows[i].w)
      begin
        prog.prog_write(rows[i].a, rows[i].d, f);
        chk_bit("wr_refused", rows[i].f, f);
      end
      else
      begin
        prog.prog_read(rows[i].a, b, f);
        chk_byte("rdata", rows[i].q, b);
        chk_bit("rd_refused", rows[i].f, f);
      end
    end
    $display("table rows done");
    cpu_read(1'h1, 1'h1, 8'h5A, 1'h0);
    pin <= 1'h1;
    idle(6);
    chk_bit("access_sel", 1'h1, pin_o);
    pin <= 1'h0;
    idle(6);
    // lock two alone is refused and leaves the level open
    prog.prog_write(SEC_ADDR, 8'hFD, f);
    chk_bit("wr_refused", 1'h1, f);
    prog.prog_read(SEC_ADDR, b, f);
    chk_byte("lock_byte", 8'hFF, b);
    chk_byte("level", 8'h00, {6'h00, lvl});
    $display("open mode done");
    prog.prog_write(SEC_ADDR, 8'hFE, f);
    chk_bit("wr_refused", 1'h0, f);
    idle(2);
    chk_byte("level", 8'h01, {6'h00, lvl});
    prog.prog_read(SEC_ADDR, b, f);
    chk_byte("lock_byte", 8'hFE, b);
    prog.prog_write(15'h0010, 8'h00, f);
    chk_bit("wr_refused", 1'h1, f);
    prog.prog_write(15'h4011, 8'h00, f);
    chk_bit("wr_refused", 1'h1, f);
    prog.prog_read(15'h0010, b, f);
    chk_byte("rdata", 8'hA5, b);
    cpu_read(1'h1, 1'h1, 8'hFF, 1'h1);
    cpu_read(1'h1, 1'h0, 8'h5A, 1'h0);
    cpu_read(1'h0, 1'h1, 8'h5A, 1'h0);
    pin <= 1'h1;
    idle(6);
    chk_bit("access_sel", 1'h0, pin_o);
    $display("lock one done");
    prog.prog_write(SEC_ADDR, 8'hFC, f);
    chk_bit("wr_refused", 1'h0, f);
    idle(2);
    chk_byte("level", 8'h02, {6'h00, lvl});
    prog.prog_read(15'h0010, b, f);
    chk_byte("rdata", 8'hFF, b);
    chk_bit("rd_refused", 1'h1, f);
    prog.prog_read(SEC_ADDR, b, f);
    chk_byte("lock_byte", 8'hFC, b);
    chk_bit("rd_refused", 1'h0, f);
    $display("full lock done");
    // second reset with the pin high: storage kept, pin latched anew
    @(posedge clk);
    rst_n <= 1'h0;
    idle(2);
    chk_byte("rdata", 8'hFF, q);
    chk_bit("access_sel", 1'h0, pin_o);
    @(posedge clk);
    rst_n <= 1'h1;
    idle(6);
    chk_byte("level", 8'h02, {6'h00, lvl});
    chk_bit("access_sel", 1'h1, pin_o);
    pin <= 1'h0;
    idle(6);
    chk_bit("access_sel", 1'h1, pin_o);
    $display("reset test done");
    wrap_up;
  end
endmodule
`default_nettype wire
